// File: ocs_consts.svh
/*
 Constants for the command/status register block: offset, field positions,
 reset value and software reset timing. Assumes a 50 MHz core clock.
*/
`ifndef OCS_CONSTS_SVH
`define OCS_CONSTS_SVH

`define OCS_CMDSTAT_OFFSET 8'h08
`define OCS_CMDSTAT_RESET 32'h0000_0000
`define OCS_BIT_SWRST 0
`define OCS_BIT_CTRLF 1
`define OCS_BIT_BULKF 2
`define OCS_BIT_OWNRQ 3
`define OCS_SOC_LO 16
`define OCS_SOC_HI 17
`define OCS_FSTATE_SUSPEND 2'h3
`define OCS_FSTATE_RESET 2'h0
`define OCS_CLK_NS 20
`define OCS_SWRST_MAX_NS 10000
// Longest time rounds down to whole cycles
`define OCS_SWRST_CYC (`OCS_SWRST_MAX_NS / `OCS_CLK_NS)
// Own reset sequence length, well inside the limit
`define OCS_SWRST_WORK 16

`endif

// File: ocs_pkg.sv
/*
 Types for the command/status register block.
 Assumes ocs_consts.svh is compiled alongside.
*/
package ocs_pkg;

  typedef enum logic [2:0] {
    OCS_IDLE = 3'b001,
    OCS_SWRST = 3'b010,
    OCS_DONE = 3'b100
  } ocs_state_t;

  typedef struct packed {
    ocs_state_t state;
    logic [4:0] cnt;
    logic [1:0] soc;
    logic own_req;
    logic bulk_f;
    logic ctrl_f;
    logic sw_rst;
    logic so_set;
    logic oc_set;
    logic [1:0] fstate;
    logic [31:0] rdata;
  } ocs_regs_t;

endpackage : ocs_pkg

// File: ocs_cmd_status.sv
/*
 Command/status register of an open host controller function: write-to-set
 commands, overrun counter, ownership request, list filled flags and the
 software reset sequence. Assumes a synchronous register port from the host
 bus decoder and single-cycle event pulses from the list processing engine.
*/
`timescale 1ns/1ns
`include "ocs_consts.svh"

module ocs_cmd_status
  import ocs_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  input wire logic OVERRUN_I,
  input wire logic OWN_DONE_I,
  input wire logic BULK_HEAD_I,
  input wire logic BULK_TD_I,
  input wire logic CTRL_HEAD_I,
  input wire logic CTRL_TD_I,
  output logic BULK_RUN_O,
  output logic CTRL_RUN_O,
  output logic OVERRUN_FLAG_SET_O,
  output logic OWNERSHIP_CHANGED_SET_O,
  output logic OP_REG_RESET_O,
  output logic HOST_BUS_HOLD_O,
  output logic [1:0] FUNC_STATE_O
);

  ocs_regs_t r_r;
  ocs_regs_t r_nxt;
  logic wr_hit;
  logic [31:0] cur;

  assign wr_hit = REG_WR_I && (REG_ADDR_I == `OCS_CMDSTAT_OFFSET);

  always_comb begin
    cur = 32'h0000_0000;
    cur[`OCS_SOC_HI:`OCS_SOC_LO] = r_r.soc;
    cur[`OCS_BIT_OWNRQ] = r_r.own_req;
    cur[`OCS_BIT_BULKF] = r_r.bulk_f;
    cur[`OCS_BIT_CTRLF] = r_r.ctrl_f;
    cur[`OCS_BIT_SWRST] = r_r.sw_rst;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    r_nxt.so_set = 1'b0;
    r_nxt.oc_set = 1'b0;
    if (REG_RD_I && (REG_ADDR_I == `OCS_CMDSTAT_OFFSET)) begin
      r_nxt.rdata = cur;
    end else begin
      r_nxt.rdata = 32'h0000_0000;
    end
    if (BULK_HEAD_I && r_r.bulk_f) begin
      r_nxt.bulk_f = 1'b0;
    end
    if (CTRL_HEAD_I && r_r.ctrl_f) begin
      r_nxt.ctrl_f = 1'b0;
    end
    // descriptor found keeps bulk going; set beats the head clear
    if (BULK_TD_I) begin
      r_nxt.bulk_f = 1'b1;
    end
    if (CTRL_TD_I) begin
      r_nxt.ctrl_f = 1'b1;
    end
    // wrapping count, independent of status flag
    if (OVERRUN_I) begin
      r_nxt.soc = r_r.soc + 2'h1;
      r_nxt.so_set = 1'b1;
    end
    if (OWN_DONE_I) begin
      r_nxt.own_req = 1'b0;
    end
    // write-to-set; software sets win over hardware clears
    if (wr_hit) begin
      r_nxt.soc = r_nxt.soc | REG_WDATA_I[`OCS_SOC_HI:`OCS_SOC_LO];
      r_nxt.bulk_f = r_nxt.bulk_f | REG_WDATA_I[`OCS_BIT_BULKF];
      r_nxt.ctrl_f = r_nxt.ctrl_f | REG_WDATA_I[`OCS_BIT_CTRLF];
      // each new request raises ownership changed, except one written while in OCS_SWRST
      if (REG_WDATA_I[`OCS_BIT_OWNRQ]) begin
        r_nxt.own_req = 1'b1;
        r_nxt.oc_set = 1'b1;
      end
      if (REG_WDATA_I[`OCS_BIT_SWRST]) begin
        r_nxt.sw_rst = 1'b1;
      end
    end
    case (r_r.state)
      OCS_IDLE: begin
        if (r_nxt.sw_rst) begin
          r_nxt.state = OCS_SWRST;
          r_nxt.cnt = 5'h00;
        end
      end
      OCS_SWRST: begin
        // only operational state here, root hub untouched
        r_nxt.soc = 2'h0;
        r_nxt.own_req = 1'b0;
        r_nxt.bulk_f = 1'b0;
        r_nxt.ctrl_f = 1'b0;
        r_nxt.so_set = 1'b0;
        r_nxt.oc_set = 1'b0;
        r_nxt.cnt = r_r.cnt + 5'h01;
        if (r_r.cnt == 5'(`OCS_SWRST_WORK - 1)) begin
          r_nxt.state = OCS_DONE;
        end
      end
      OCS_DONE: begin
        r_nxt.sw_rst = 1'b0;
        r_nxt.fstate = `OCS_FSTATE_SUSPEND;
        r_nxt.state = OCS_IDLE;
      end
      default: begin
        r_nxt.state = OCS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      r_r <= '{state: OCS_IDLE, cnt: 5'h00, soc: 2'h0, own_req: 1'b0,
               bulk_f: 1'b0, ctrl_f: 1'b0, sw_rst: 1'b0, so_set: 1'b0,
               oc_set: 1'b0, fstate: `OCS_FSTATE_RESET,
               rdata: `OCS_CMDSTAT_RESET};
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA_O = r_r.rdata;
  // processing permitted only when flag seen set
  assign BULK_RUN_O = BULK_HEAD_I && r_r.bulk_f && !r_r.sw_rst;
  assign CTRL_RUN_O = CTRL_HEAD_I && r_r.ctrl_f && !r_r.sw_rst;
  assign OVERRUN_FLAG_SET_O = r_r.so_set;
  assign OWNERSHIP_CHANGED_SET_O = r_r.oc_set;
  assign OP_REG_RESET_O = (r_r.state == OCS_SWRST);
  // bus quiet while reset pending or running
  assign HOST_BUS_HOLD_O = r_r.sw_rst;
  assign FUNC_STATE_O = r_r.fstate;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Reset end falls two cycles after the last busy count
  localparam int swrst_end = `OCS_SWRST_WORK + 2;
  // Longest software reset allowed, in whole cycles
  localparam int swrst_limit = `OCS_SWRST_CYC;

  sequence s_rst_req;
    r_r.state == OCS_IDLE && r_nxt.sw_rst;
  endsequence

  sequence s_rst_end;
    ##swrst_end !r_r.sw_rst && FUNC_STATE_O == 2'h3;
  endsequence

  a_overrun_count: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    OVERRUN_I && !wr_hit && r_r.state == OCS_IDLE |=> r_r.soc == $past(r_r.soc) + 2'h1)
    else $error("overrun count did not increment");
  a_overrun_flag: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    OVERRUN_I && r_r.state == OCS_IDLE |=> OVERRUN_FLAG_SET_O)
    else $error("overrun flag not set");
  a_soc_wrap: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    OVERRUN_I && !wr_hit && r_r.soc == 2'h3 && r_r.state == OCS_IDLE |=> r_r.soc == 2'h0)
    else $error("overrun count did not wrap");
  a_write_set: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    wr_hit && REG_WDATA_I[2] && r_r.state == OCS_IDLE |=> r_r.bulk_f)
    else $error("written one did not set");
  a_own_change: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    wr_hit && REG_WDATA_I[3] && r_r.state == OCS_IDLE
      |=> OWNERSHIP_CHANGED_SET_O && r_r.own_req)
    else $error("ownership changed not raised");
  a_own_clear: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    OWN_DONE_I && !(wr_hit && REG_WDATA_I[3]) |=> !r_r.own_req)
    else $error("ownership request not cleared");
  a_bulk_consume: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    BULK_HEAD_I && !BULK_TD_I && !wr_hit |=> !r_r.bulk_f)
    else $error("bulk filled not consumed");
  a_ctrl_found: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    CTRL_TD_I && r_r.state == OCS_IDLE |=> r_r.ctrl_f)
    else $error("control filled not set");
  a_swrst_done: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    s_rst_req |-> s_rst_end)
    else $error("software reset did not finish");
  a_bus_hold: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    OP_REG_RESET_O |-> HOST_BUS_HOLD_O && !BULK_RUN_O && !CTRL_RUN_O)
    else $error("bus activity during reset");

  // ----------------------------------------------------------------
  // Register access checks
  // ----------------------------------------------------------------
  sequence s_rst_busy;
    r_r.state == OCS_SWRST;
  endsequence

  sequence s_fields_clear;
    r_r.soc == 2'h0 && !r_r.own_req && !r_r.bulk_f && !r_r.ctrl_f;
  endsequence

  a_write_ctrl: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    wr_hit && REG_WDATA_I[1] && r_r.state == OCS_IDLE |=> r_r.ctrl_f)
    else $error("written one did not set control");

  a_write_keep: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    wr_hit && !REG_WDATA_I[2] && !BULK_HEAD_I && !BULK_TD_I && r_r.state == OCS_IDLE
      |=> r_r.bulk_f == $past(r_r.bulk_f))
    else $error("written zero changed bulk filled");

  a_write_hold: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    wr_hit && !REG_WDATA_I[1] && !CTRL_HEAD_I && !CTRL_TD_I && r_r.state == OCS_IDLE
      |=> r_r.ctrl_f == $past(r_r.ctrl_f))
    else $error("written zero changed control filled");

  a_read_back: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    REG_RD_I && REG_ADDR_I == `OCS_CMDSTAT_OFFSET |=> REG_RDATA_O == $past(cur))
    else $error("read data not current value");

  a_read_idle: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !(REG_RD_I && REG_ADDR_I == `OCS_CMDSTAT_OFFSET) |=> REG_RDATA_O == 32'h0000_0000)
    else $error("read data without read hit");

  a_read_rsvd: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    REG_RDATA_O[31:18] == 14'h0000 && REG_RDATA_O[15:4] == 12'h000)
    else $error("reserved bits read nonzero");

  // ----------------------------------------------------------------
  // Event checks
  // ----------------------------------------------------------------
  // count ignores pending flag
  a_soc_flagged: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    OVERRUN_I && r_r.so_set && !wr_hit && r_r.state == OCS_IDLE
      |=> r_r.soc == $past(r_r.soc) + 2'h1)
    else $error("overrun count skipped with flag set");

  a_oc_quiet: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !(wr_hit && REG_WDATA_I[3]) |=> !OWNERSHIP_CHANGED_SET_O)
    else $error("ownership changed without request");

  a_own_hold: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !r_r.own_req && !(wr_hit && REG_WDATA_I[3]) |=> !r_r.own_req)
    else $error("ownership request set by itself");

  a_bulk_skip: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    BULK_HEAD_I && !r_r.bulk_f |-> !BULK_RUN_O)
    else $error("bulk processed while empty");

  a_bulk_found: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    BULK_TD_I && r_r.state == OCS_IDLE |=> r_r.bulk_f)
    else $error("bulk filled not set");

  a_ctrl_consume: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    CTRL_HEAD_I && !CTRL_TD_I && !wr_hit |=> !r_r.ctrl_f)
    else $error("control filled not consumed");

  a_ctrl_skip: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    CTRL_HEAD_I && !r_r.ctrl_f |-> !CTRL_RUN_O)
    else $error("control processed while empty");

  // ----------------------------------------------------------------
  // Software and hardware reset checks
  // ----------------------------------------------------------------
  // request starts reset
  a_rst_enter: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    s_rst_req |=> s_rst_busy and OP_REG_RESET_O)
    else $error("software reset not entered");

  a_rst_clear: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    s_rst_busy |=> s_fields_clear)
    else $error("fields not cleared by software reset");

  a_rst_limit: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    s_rst_req |-> ##[1:swrst_limit] !r_r.sw_rst)
    else $error("software reset too long");

  a_rst_quiet: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    r_r.sw_rst |-> HOST_BUS_HOLD_O && !BULK_RUN_O && !CTRL_RUN_O)
    else $error("list run during software reset");

  a_rst_release: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    r_r.state == OCS_DONE |=> !HOST_BUS_HOLD_O && r_r.state == OCS_IDLE)
    else $error("reset bit not cleared at done");

  a_fstate_soft: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    r_r.state == OCS_DONE |=> FUNC_STATE_O == `OCS_FSTATE_SUSPEND)
    else $error("not suspended after software reset");

  a_hard_reset: assert property (@(posedge SYS_CLK_I)
    SYS_RST_I |=> FUNC_STATE_O == `OCS_FSTATE_RESET && REG_RDATA_O == 32'h0000_0000
      && !r_r.sw_rst && r_r.state == OCS_IDLE)
    else $error("hardware reset left state behind");

endmodule : ocs_cmd_status

// File: tb_top.sv
/*
 Self-checking bench for the command/status register block.
 Assumes the block's register strobes, event pulses and timing as handed over.
*/
`timescale 1ns/1ns
`include "ocs_consts.svh"

module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [5:0] ev_v = 6'h00;
  logic [31:0] rdata;
  logic brun, crun, so_p, oc_p, opr, hold;
  logic [1:0] fst;
  int bad_count = 0;
  int n_checks = 0;
  int i, n;

  always #10 clk = ~clk;

  ocs_cmd_status i_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .OVERRUN_I(ev_v[5]),
    .OWN_DONE_I(ev_v[4]), .BULK_HEAD_I(ev_v[3]), .BULK_TD_I(ev_v[2]), .CTRL_HEAD_I(ev_v[1]),
    .CTRL_TD_I(ev_v[0]), .BULK_RUN_O(brun), .CTRL_RUN_O(crun), .OVERRUN_FLAG_SET_O(so_p),
    .OWNERSHIP_CHANGED_SET_O(oc_p), .OP_REG_RESET_O(opr), .HOST_BUS_HOLD_O(hold),
    .FUNC_STATE_O(fst));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Strobes are set once per step and never dropped at the end, so two
  // back-to-back calls never assign a signal twice in one time step
  task put(input logic w, input logic r, input logic [5:0] e);
    wr = w;
    rd = r;
    ev_v = e;
  endtask : put

  task step;
    @(posedge clk);
    #1;
  endtask : step

  task wr_t(input logic [7:0] a, input logic [31:0] d);
    put(1'b1, 1'b0, 6'h00);
    addr = a;
    wdata = d;
    step();
  endtask : wr_t

  task rd_t(input logic [7:0] a, input logic [31:0] exp);
    put(1'b0, 1'b1, 6'h00);
    addr = a;
    step();
    chk(rdata, exp);
  endtask : rd_t

  // Run outputs are combinational, so they are looked at before the edge
  task ev(input logic [5:0] m, input logic [1:0] run);
    put(1'b0, 1'b0, m);
    #2;
    chk({brun, crun}, run);
    step();
  endtask : ev

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(fst, `OCS_FSTATE_RESET);
    rd_t(8'h08, 32'h0000_0000);
    wr_t(8'h08, 32'h0000_0002);
    wr_t(8'h08, 32'h0000_0004);
    rd_t(8'h08, 32'h0000_0006);
    wr_t(8'h0C, 32'h0000_0008);
    rd_t(8'h10, 32'h0000_0000);
    rd_t(8'h08, 32'h0000_0006);
    ev(6'h02, 2'b01);
    rd_t(8'h08, 32'h0000_0004);
    ev(6'h02, 2'b00);
    ev(6'h08, 2'b10);
    ev(6'h08, 2'b00);
    rd_t(8'h08, 32'h0000_0000);
    ev(6'h01, 2'b00);
    ev(6'h04, 2'b00);
    rd_t(8'h08, 32'h0000_0006);
    for (i = 1; i <= 5; i++) begin
      ev(6'h20, 2'b00);
      chk(so_p, 1'b1);
      rd_t(8'h08, {14'h0000, i[1:0], 16'h0006});
    end
    wr_t(8'h08, 32'h0000_0008);
    chk(oc_p, 1'b1);
    rd_t(8'h08, 32'h0001_000E);
    ev(6'h10, 2'b00);
    rd_t(8'h08, 32'h0001_0006);
    wr_t(8'h08, 32'h0000_0001);
    chk({hold, opr}, 2'b11);
    put(1'b0, 1'b0, 6'h00);
    // Bounded by the longest reset time allowed at this clock rate
    for (n = 1; n <= `OCS_SWRST_CYC && hold === 1'b1; n++) begin
      step();
    end
    if (hold !== 1'b0) begin
      bad_count++;
      $display("[FAIL] %0t software reset never finished", $time);
    end else begin
      chk(fst, `OCS_FSTATE_SUSPEND);
      rd_t(8'h08, 32'h0000_0000);
    end
    conclude();
  end
endmodule : tb_top
